// ===== hw/sample_input_clock_port.v
// Receive side of a digital I/Q sample port: clock select, phase, capture, FIFO.
// Assumes a register master on sys_clk and a baseband reader pulling rdReq.
`timescale 1ns/1ps
`include "sample_port_defines.vh"
module sample_input_clock_port #(
	parameter IQ_W        = 8,
	parameter DEPTH_LOG   = 4,
	parameter SKEW_W      = 4,
	parameter LOGIC_W     = 2,
	parameter REF_TIMEOUT = `REF_TIMEOUT
) (
	input  wire                 sys_clk,
	input  wire                 rst_b,
	input  wire [3:0]           addr,
	input  wire [31:0]          wrData,
	input  wire                 wrStb,
	input  wire                 rdStb,
	output reg  [31:0]          rdData,
	output wire                 irq,
	input  wire                 optOutFitted,
	input  wire                 optInFitted,
	input  wire                 formatActive,
	input  wire                 extClkIn,
	input  wire                 freqRefIn,
	input  wire                 devClkIn,
	output reg                  devClkOut,
	output reg                  devClkOe,
	output reg                  clkOut,
	input  wire [2*IQ_W-1:0]    dataIn,
	output reg  [LOGIC_W-1:0]   logicType,
	output reg                  moduleOn,
	input  wire                 rdReq,
	output wire [2*IQ_W-1:0]    sampleData,
	output wire                 sampleValid
);
	localparam W = 2 * IQ_W;

	reg  [8:0]          ctrl_q;
	reg  [`RATE_W-1:0]  rate_q;
	reg  [SKEW_W-1:0]   skew_q;
	reg  [LOGIC_W-1:0]  logicReq_q;
	reg                 logicPend_q;
	reg  [`ST_W-1:0]    status_q;
	reg  [`ST_W-1:0]    mask_q;
	reg  [`ERR_W-1:0]   errCode_q;
	reg  [1:0]          strapMeta_q;
	reg  [1:0]          strap_q;
	reg  [W-1:0]        dataMeta_q;
	reg  [W-1:0]        dataSync_q;
	reg  [31:0]         nco_q;
	reg                 intLast_q;
	reg  [15:0]         refIdle_q;
	reg  [15:0]         perCnt_q;
	reg  [15:0]         period_q;
	reg  [15:0]         delay_q;
	reg                 pend_q;
	reg  [W-1:0]        shift_q;
	reg  [7:0]          bitCnt_q;
	reg  [IQ_W-1:0]     iHold_q;
	reg                 half_q;
	reg                 wrEn_q;
	reg  [W-1:0]        wrWord_q;
	reg  [`ST_W-1:0]    evt;
	reg  [`ST_W-1:0]    stNext;
	reg                 selRise;
	reg                 selFall;
	reg                 selLevel;

	wire        extLvl, extRise, extFall;
	wire        devLvl, devRise, devFall;
	wire        refLvl, refRise;
	wire        bothFitted;
	wire        refLock;
	wire        intLvl;
	wire        intRise;
	wire        intFall;
	wire        active;
	wire [1:0]  cfg;
	wire [1:0]  src;
	wire [1:0]  phEff;
	wire        skewOn;
	wire [15:0] delayNext;
	wire        startEdge;
	wire        capture;
	wire        fifoFull;
	wire        fifoEmpty;
	wire [DEPTH_LOG:0] fifoLevel;
	wire [34:0] ncoProd;

	function inRange;
		input [`RATE_W-1:0] r;
		input [`RATE_W-1:0] lo;
		input [`RATE_W-1:0] hi;
		begin
			inRange = (r >= lo) && (r <= hi);
		end
	endfunction

	edge_sync uExt (.clk(sys_clk), .rst_b(rst_b), .pin(extClkIn),
		.level(extLvl), .rise(extRise), .fall(extFall));
	edge_sync uDev (.clk(sys_clk), .rst_b(rst_b), .pin(devClkIn),
		.level(devLvl), .rise(devRise), .fall(devFall));
	edge_sync uRef (.clk(sys_clk), .rst_b(rst_b), .pin(freqRefIn),
		.level(refLvl), .rise(refRise), .fall());

	assign bothFitted = strap_q[0] & strap_q[1];
	assign cfg        = ctrl_q[`CTRL_CFG_HI:`CTRL_CFG_LO];
	assign src        = ctrl_q[`CTRL_SRC_HI:`CTRL_SRC_LO];
	assign active     = moduleOn & ~ctrl_q[`CTRL_DIR];
	// Polarity folds into the phase as a half turn
	assign phEff = inRange(rate_q, `RATE_10MHZ, `RATE_200MHZ) ?
		(ctrl_q[`CTRL_PH_HI:`CTRL_PH_LO] + {ctrl_q[`CTRL_POL], 1'b0}) :
		((ctrl_q[`CTRL_PH_HI:`CTRL_PH_LO] + {ctrl_q[`CTRL_POL], 1'b0}) & 2'h2);
	assign skewOn = (rate_q >= `RATE_25MHZ);

	// Rate steps the generator on the internal source; it also sets phase range and skew
	assign ncoProd = rate_q * `NCO_SCALE;
	assign refLock = (refIdle_q < REF_TIMEOUT[15:0]);
	assign intLvl  = nco_q[31];
	assign intRise = intLvl & ~intLast_q;
	assign intFall = ~intLvl & intLast_q;

	always @* begin
		selRise  = 1'b0;
		selFall  = 1'b0;
		selLevel = 1'b0;
		case (src)
			`SRC_EXTERNAL: begin
				selRise  = extRise;
				selFall  = extFall;
				selLevel = extLvl;
			end
			`SRC_DEVICE: begin
				selRise  = devRise;
				selFall  = devFall;
				selLevel = devLvl;
			end
			`SRC_INTERNAL: begin
				// Ext pin ignored here; a driven pin is only an outside hazard
				selRise  = intRise;
				selFall  = intFall;
				selLevel = intLvl;
			end
			default: begin
				selRise  = 1'b0;
				selFall  = 1'b0;
				selLevel = 1'b0;
			end
		endcase
	end

	assign startEdge = phEff[1] ? selFall : selRise;
	assign delayNext = (phEff[0] ? {2'h0, period_q[15:2]} : 16'h0000) +
		(skewOn ? {{(16-SKEW_W){1'b0}}, skew_q} : 16'h0000);
	assign capture = active & ((startEdge & (delayNext == 16'h0000)) |
		(pend_q & (delay_q == 16'h0001)));

	always @* begin
		evt = {`ST_W{1'b0}};
		evt[`ST_OVF] = wrEn_q & fifoFull;
		evt[`ST_UDF] = active & rdReq & fifoEmpty;
		evt[`ST_FMT] = moduleOn & ~formatActive;
		stNext = status_q;
		if (rdStb && addr == `ADDR_STATUS) begin
			stNext = {`ST_W{1'b0}};
		end
		// A new event outweighs the read that clears
		stNext = stNext | evt;
	end

	assign irq = |(status_q & mask_q);

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q      <= 9'h000;
			rate_q      <= `RATE_RESET;
			skew_q      <= {SKEW_W{1'b0}};
			logicReq_q  <= {LOGIC_W{1'b0}};
			logicPend_q <= 1'b0;
			logicType   <= {LOGIC_W{1'b0}};
			moduleOn    <= 1'b0;
			status_q    <= {`ST_W{1'b0}};
			mask_q      <= {`ST_W{1'b0}};
			errCode_q   <= `ERR_NONE;
			rdData      <= 32'h00000000;
			strapMeta_q <= 2'h0;
			strap_q     <= 2'h0;
		end else begin
			strapMeta_q <= {optOutFitted, optInFitted};
			strap_q     <= strapMeta_q;
			status_q    <= stNext;
			if (evt[`ST_OVF]) begin
				errCode_q <= `ERR_OVERFLOW;
			end else if (evt[`ST_UDF]) begin
				errCode_q <= `ERR_UNDERFLOW;
			end
			if (!formatActive) begin
				moduleOn <= 1'b0;
			end else if (wrStb && addr == `ADDR_CTRL) begin
				moduleOn <= wrData[`CTRL_EN];
			end
			if (wrStb) begin
				case (addr)
					`ADDR_CTRL: begin
						ctrl_q <= wrData[8:0];
						ctrl_q[`CTRL_DIR] <= bothFitted & wrData[`CTRL_DIR];
					end
					`ADDR_RATE:  rate_q <= wrData[`RATE_W-1:0];
					`ADDR_SKEW:  skew_q <= wrData[SKEW_W-1:0];
					`ADDR_LOGIC: begin
						logicReq_q  <= wrData[LOGIC_W-1:0];
						logicPend_q <= 1'b1;
					end
					`ADDR_CONFIRM: begin
						if (logicPend_q) begin
							logicType <= logicReq_q;
						end
						logicPend_q <= 1'b0;
					end
					`ADDR_MASK:  mask_q <= wrData[`ST_W-1:0];
					default: begin
					end
				endcase
			end else if (!bothFitted) begin
				ctrl_q[`CTRL_DIR] <= 1'b0;
			end
			rdData <= 32'h00000000;
			if (rdStb) begin
				case (addr)
					`ADDR_CTRL:    rdData <= {23'h000000, ctrl_q[8:1], moduleOn};
					`ADDR_RATE:    rdData <= {14'h0000, rate_q};
					`ADDR_SKEW:    rdData <= {{(32-SKEW_W){1'b0}}, skew_q};
					`ADDR_LOGIC:   rdData <= {{(31-LOGIC_W){1'b0}}, logicPend_q, logicReq_q};
					`ADDR_STATUS:  rdData <= {{(32-`ST_W){1'b0}}, status_q};
					`ADDR_MASK:    rdData <= {{(32-`ST_W){1'b0}}, mask_q};
					`ADDR_INFO:    rdData <= {{(25-DEPTH_LOG){1'b0}}, fifoLevel,
						refLock, skewOn, phEff, bothFitted, selLevel};
					`ADDR_ERRCODE: rdData <= {{(32-`ERR_W){1'b0}}, errCode_q};
					default:       rdData <= 32'h00000000;
				endcase
			end
		end
	end

	// Internal clock; limited to half of sys_clk by construction
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			nco_q     <= 32'h00000000;
			intLast_q <= 1'b0;
			refIdle_q <= 16'hFFFF;
		end else begin
			intLast_q <= intLvl;
			if (refRise) begin
				refIdle_q <= 16'h0000;
			end else if (refIdle_q != 16'hFFFF) begin
				refIdle_q <= refIdle_q + 16'h0001;
			end
			if (src == `SRC_INTERNAL && refLock) begin
				nco_q <= nco_q + ncoProd[31:0];
			end else begin
				nco_q <= 32'h00000000;
			end
		end
	end

	// Clock forwarding; device pin is an input when the device is the source
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			clkOut    <= 1'b0;
			devClkOut <= 1'b0;
			devClkOe  <= 1'b0;
		end else begin
			clkOut    <= selLevel;
			devClkOut <= selLevel;
			devClkOe  <= (src != `SRC_DEVICE);
		end
	end

	// Period tracking and phase delayed capture
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			perCnt_q   <= 16'h0000;
			period_q   <= 16'h0000;
			delay_q    <= 16'h0000;
			pend_q     <= 1'b0;
			dataMeta_q <= {W{1'b0}};
			dataSync_q <= {W{1'b0}};
		end else begin
			dataMeta_q <= dataIn;
			dataSync_q <= dataMeta_q;
			if (selRise) begin
				period_q <= perCnt_q + 16'h0001;
				perCnt_q <= 16'h0000;
			end else if (perCnt_q != 16'hFFFF) begin
				perCnt_q <= perCnt_q + 16'h0001;
			end
			if (active && startEdge && delayNext != 16'h0000) begin
				pend_q  <= 1'b1;
				delay_q <= delayNext;
			end else if (pend_q && delay_q != 16'h0001) begin
				delay_q <= delay_q - 16'h0001;
			end else begin
				pend_q  <= 1'b0;
			end
		end
	end

	// Word assembly per port arrangement
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_q  <= {W{1'b0}};
			bitCnt_q <= 8'h00;
			iHold_q  <= {IQ_W{1'b0}};
			half_q   <= 1'b0;
			wrEn_q   <= 1'b0;
			wrWord_q <= {W{1'b0}};
		end else begin
			wrEn_q <= 1'b0;
			if (!active) begin
				bitCnt_q <= 8'h00;
				half_q   <= 1'b0;
			end else if (capture) begin
				case (cfg)
					`CFG_SERIAL: begin
						shift_q <= {shift_q[W-2:0], dataSync_q[0]};
						if (bitCnt_q == W - 1) begin
							bitCnt_q <= 8'h00;
							wrEn_q   <= 1'b1;
							wrWord_q <= {shift_q[W-2:0], dataSync_q[0]};
						end else begin
							bitCnt_q <= bitCnt_q + 8'h01;
						end
					end
					`CFG_PARALLEL: begin
						wrEn_q   <= 1'b1;
						wrWord_q <= dataSync_q;
					end
					`CFG_INTERLEAVE: begin
						half_q <= ~half_q;
						if (half_q) begin
							wrEn_q   <= 1'b1;
							wrWord_q <= {iHold_q, dataSync_q[IQ_W-1:0]};
						end else begin
							iHold_q <= dataSync_q[IQ_W-1:0];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	sample_fifo #(.WIDTH(W), .DEPTH_LOG(DEPTH_LOG)) uFifo (
		.clk(sys_clk), .rst_b(rst_b), .wrEn(wrEn_q), .wrData(wrWord_q),
		.rdEn(rdReq & active), .rdData(sampleData), .rdValid(sampleValid),
		.full(fifoFull), .empty(fifoEmpty), .level(fifoLevel));
endmodule

// ===== hw/sample_port_defines.vh
// Constants for the sample input clock port: register map, fields, codes.
// Assumes a 4-bit word address and 32-bit read data on the register port.
`ifndef SAMPLE_PORT_DEFINES_VH
`define SAMPLE_PORT_DEFINES_VH

`define ADDR_CTRL      4'h0
`define ADDR_RATE      4'h1
`define ADDR_SKEW      4'h2
`define ADDR_LOGIC     4'h3
`define ADDR_CONFIRM   4'h4
`define ADDR_STATUS    4'h5
`define ADDR_MASK      4'h6
`define ADDR_INFO      4'h7
`define ADDR_ERRCODE   4'h8

`define CTRL_EN        0
`define CTRL_DIR       1
`define CTRL_CFG_LO    2
`define CTRL_CFG_HI    3
`define CTRL_SRC_LO    4
`define CTRL_SRC_HI    5
`define CTRL_PH_LO     6
`define CTRL_PH_HI     7
`define CTRL_POL       8

`define CFG_SERIAL     2'h0
`define CFG_PARALLEL   2'h1
`define CFG_INTERLEAVE 2'h2

`define SRC_EXTERNAL   2'h0
`define SRC_DEVICE     2'h1
`define SRC_INTERNAL   2'h2

`define PHASE_0        2'h0
`define PHASE_180      2'h2

`define RATE_W         18
`define RATE_10MHZ     18'h02710
`define RATE_25MHZ     18'h061A8
`define RATE_200MHZ    18'h30D40
`define RATE_RESET     18'h01388
`define NCO_SCALE      17'h1A36E

`define ERR_W          10
`define ERR_OVERFLOW   10'h323
`define ERR_UNDERFLOW  10'h324
`define ERR_NONE       10'h000

`define ST_OVF         0
`define ST_UDF         1
`define ST_FMT         2
`define ST_W           3

`define REF_TIMEOUT    16'h0400

`endif

// ===== hw/edge_sync.v
// Two-flop synchroniser for one pin, with rise and fall pulses.
// Assumes the pin is asynchronous to clk and slower than half its rate.
`timescale 1ns/1ps
module edge_sync (
	input  wire clk,
	input  wire rst_b,
	input  wire pin,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg sync_q;
	reg last_q;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~last_q;
	assign fall  = ~sync_q & last_q;
endmodule

// ===== hw/sample_fifo.v
// Input sample FIFO, one write and one read port on one clock.
// Writes while full and reads while empty are dropped here; full and empty are both reported.
`timescale 1ns/1ps
module sample_fifo #(
	parameter WIDTH     = 16,
	parameter DEPTH_LOG = 4
) (
	input  wire                 clk,
	input  wire                 rst_b,
	input  wire                 wrEn,
	input  wire [WIDTH-1:0]     wrData,
	input  wire                 rdEn,
	output reg  [WIDTH-1:0]     rdData,
	output reg                  rdValid,
	output wire                 full,
	output wire                 empty,
	output wire [DEPTH_LOG:0]   level
);
	reg [WIDTH-1:0]   mem [0:(1<<DEPTH_LOG)-1];
	reg [DEPTH_LOG:0] wrPtr_q;
	reg [DEPTH_LOG:0] rdPtr_q;
	wire              doWr;
	wire              doRd;

	assign level = wrPtr_q - rdPtr_q;
	assign full  = level[DEPTH_LOG];
	assign empty = (wrPtr_q == rdPtr_q);
	assign doWr  = wrEn & ~full;
	assign doRd  = rdEn & ~empty;

	always @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr_q[DEPTH_LOG-1:0]] <= wrData;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_q <= {(DEPTH_LOG+1){1'b0}};
			rdPtr_q <= {(DEPTH_LOG+1){1'b0}};
			rdData  <= {WIDTH{1'b0}};
			rdValid <= 1'b0;
		end else begin
			rdValid <= doRd;
			if (doWr) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (doRd) begin
				rdPtr_q <= rdPtr_q + 1'b1;
				rdData  <= mem[rdPtr_q[DEPTH_LOG-1:0]];
			end
		end
	end
endmodule

// ===== verif/sample_port_checker.sv
// Assertions on the sample port's pins and register port.
// Bound into the top module; sees its ports only.
`timescale 1ns/1ps
`include "sample_port_defines.vh"
module sample_port_checker #(
	parameter LOGIC_W = 2
) (
	input wire               sys_clk,
	input wire               rst_b,
	input wire [3:0]         addr,
	input wire [31:0]        wrData,
	input wire               wrStb,
	input wire               rdStb,
	input wire [31:0]        rdData,
	input wire               formatActive,
	input wire               devClkIn,
	input wire               devClkOut,
	input wire               clkOut,
	input wire               devClkOe,
	input wire [LOGIC_W-1:0] logicType,
	input wire               moduleOn,
	input wire               rdReq,
	input wire               sampleValid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_rdQuiet;
		rdData != 32'h0 |-> $past(rdStb);
	endproperty
	a_rdQuiet: assert property (p_rdQuiet) else $error("read data without strobe");
	property p_clkMirror;
		clkOut == devClkOut;
	endproperty
	a_clkMirror: assert property (p_clkMirror) else $error("clock outputs differ");
	// Idle link only: a toggling clock never holds six cycles
	property p_devFollow;
		(!devClkOe && $stable(devClkIn))[*6] |-> clkOut == devClkIn;
	endproperty
	a_devFollow: assert property (p_devFollow) else $error("device clock not routed");
	property p_fmtLoss;
		moduleOn && !formatActive |=> !moduleOn;
	endproperty
	a_fmtLoss: assert property (p_fmtLoss) else $error("module stayed on");
	property p_fmtHold;
		!moduleOn && !formatActive |=> !moduleOn;
	endproperty
	a_fmtHold: assert property (p_fmtHold) else $error("module on without format");
	property p_onByWrite;
		$rose(moduleOn) |-> $past(wrStb && addr == `ADDR_CTRL && wrData[`CTRL_EN]);
	endproperty
	a_onByWrite: assert property (p_onByWrite) else $error("module on unasked");
	property p_logicConfirm;
		logicType != $past(logicType) |-> $past(wrStb && addr == `ADDR_CONFIRM);
	endproperty
	a_logicConfirm: assert property (p_logicConfirm) else $error("logic type unconfirmed");
	property p_validReq;
		sampleValid |-> $past(rdReq);
	endproperty
	a_validReq: assert property (p_validReq) else $error("sample without request");
endmodule
bind sample_input_clock_port sample_port_checker #(.LOGIC_W(LOGIC_W)) uChecker (
	.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrStb(wrStb),
	.rdStb(rdStb), .rdData(rdData), .formatActive(formatActive), .devClkIn(devClkIn),
	.devClkOut(devClkOut), .clkOut(clkOut), .devClkOe(devClkOe), .logicType(logicType),
	.moduleOn(moduleOn), .rdReq(rdReq), .sampleValid(sampleValid));

// ===== verif/sample_dut_model.sv
// Device under test sending sample words with its own link clock.
// Clock stands low between frames; data lines invert when released.
`timescale 1ns/1ps
`include "sample_port_defines.vh"
module sample_dut_model (
	input  wire        go,
	input  wire [1:0]  cfg,
	input  wire        neg,
	input  wire [5:0]  n,
	input  wire [15:0] base,
	output reg         linkClk,
	output reg  [15:0] data,
	output reg         busy
);
	integer     w, u, us;
	reg  [15:0] wd;
	reg  [15:0] val;
	initial begin
		linkClk = 1'b0;
		data = 16'h0;
		busy = 1'b0;
	end
	always @(posedge go) begin
		busy = 1'b1;
		us = (cfg == `CFG_SERIAL) ? 16 : (cfg == `CFG_PARALLEL) ? 1 : 2;
		for (w = 0; w < n; w = w + 1) begin
			wd = base + w[15:0];
			for (u = 0; u < us; u = u + 1) begin
				if (us == 16)
					val = {16{wd[15 - u]}};
				else if (us == 2)
					val = u ? {~wd[7:0], wd[7:0]} : {~wd[15:8], wd[15:8]};
				else
					val = wd;
				// Launch half a period from the capturing edge
				if (!neg)
					data = val;
				#100 linkClk = 1'b1;
				if (neg)
					data = val;
				#100 linkClk = 1'b0;
			end
		end
		#100 data = ~data;
		busy = 1'b0;
	end
endmodule

// ===== verif/tb_sample_input_clock_port.sv
// Self-checking bench for the sample input clock port.
// One 40 MHz clock; device model on the pins, link clock 200 ns.
`timescale 1ns/1ps
`include "sample_port_defines.vh"
module tb_sample_input_clock_port;
	localparam [107:0] RATES = {18'h30D41, 18'h30D40, 18'h061A8, 18'h061A7, 18'h02710, 18'h0270F};
	localparam [31:0]  ALL = 32'hFFFFFFFF;
	reg         sys_clk = 1'b0;
	reg         rst_b = 1'b0;
	reg  [3:0]  addr = 4'h0;
	reg  [31:0] wrData = 32'h0;
	reg         wrStb = 1'b0, rdStb = 1'b0, rdReq = 1'b0;
	reg         optOut = 1'b0, optIn = 1'b1, fmtOn = 1'b1, freqRef = 1'b0;
	reg         useDev = 1'b0, pNeg = 1'b0, pGo = 1'b0;
	reg  [1:0]  pCfg = 2'h0;
	reg  [5:0]  pN = 6'h0;
	reg  [15:0] pBase = 16'h0;
	wire        pClk, pBusy, irq, devClkOut, devClkOe, clkOut, moduleOn, sampleValid;
	wire [15:0] pData, sampleData;
	wire [31:0] rdData;
	wire [1:0]  logicType;
	integer     errors = 0;
	integer     num_checks = 0;
	integer     i, j, cnt;
	reg  [31:0] d;
	reg  [1:0]  ph;
	reg         v;
	reg  [15:0] sd;
	always #12.5 sys_clk = ~sys_clk;
	always #50 freqRef = ~freqRef;
	sample_dut_model model (.go(pGo), .cfg(pCfg), .neg(pNeg), .n(pN), .base(pBase),
		.linkClk(pClk), .data(pData), .busy(pBusy));
	sample_input_clock_port #(.REF_TIMEOUT(16'h0010)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .irq(irq), .optOutFitted(optOut),
		.optInFitted(optIn), .formatActive(fmtOn), .extClkIn(useDev ? 1'b0 : pClk),
		.freqRefIn(freqRef), .devClkIn(useDev ? pClk : 1'b0), .devClkOut(devClkOut),
		.devClkOe(devClkOe), .clkOut(clkOut), .dataIn(pData), .logicType(logicType),
		.moduleOn(moduleOn), .rdReq(rdReq), .sampleData(sampleData),
		.sampleValid(sampleValid));
	task chk(input [8*10-1:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] dt);
		begin
			@(posedge sys_clk);
			addr <= a;
			wrData <= dt;
			wrStb <= 1'b1;
			@(posedge sys_clk);
			wrStb <= 1'b0;
		end
	endtask
	task rchk(input [8*10-1:0] nm, input [3:0] a, input [31:0] m, input [31:0] e);
		begin
			@(posedge sys_clk);
			addr <= a;
			rdStb <= 1'b1;
			@(posedge sys_clk);
			rdStb <= 1'b0;
			@(negedge sys_clk);
			chk(nm, rdData & m, e);
		end
	endtask
	task frame(input [1:0] c, input ng, input [5:0] n, input [15:0] b);
		begin
			pCfg <= c;
			pNeg <= ng;
			pN <= n;
			pBase <= b;
			pGo <= 1'b1;
			@(posedge sys_clk);
			pGo <= 1'b0;
			@(posedge sys_clk);
			while (pBusy) @(posedge sys_clk);
			repeat (6) @(posedge sys_clk);
			@(negedge sys_clk);
		end
	endtask
	task pull(output vo, output [15:0] so);
		begin
			@(posedge sys_clk);
			rdReq <= 1'b1;
			@(posedge sys_clk);
			rdReq <= 1'b0;
			@(negedge sys_clk);
			vo = sampleValid;
			so = sampleData;
		end
	endtask
	task drain(input [5:0] n, input [15:0] b);
		integer k;
		begin
			for (k = 0; k < n; k = k + 1) begin
				pull(v, sd);
				chk("valid", v, 1'b1);
				chk("sample", sd, b + k[15:0]);
			end
		end
	endtask
	task countRises(output integer c);
		integer k;
		reg     prev;
		begin
			c = 0;
			// Skip the edge that may still carry the previous source
			@(negedge sys_clk);
			prev = clkOut;
			for (k = 0; k < 400; k = k + 1) begin
				@(negedge sys_clk);
				if (clkOut && !prev)
					c = c + 1;
				prev = clkOut;
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", num_checks, errors);
			if (errors == 0 && num_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Whole run is near 43 us; over five times that means a hang
	initial begin
		#250000;
		errors = errors + 1;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rchk("ctrl", `ADDR_CTRL, ALL, 32'h0);
		rchk("rate", `ADDR_RATE, ALL, {14'h0, `RATE_RESET});
		wr(4'hF, ALL);
		rchk("unmapped", 4'h9, ALL, 32'h0);
		$display("reset test done");
		wr(`ADDR_CTRL, 32'h2);
		rchk("dirone", `ADDR_CTRL, 32'h2, 32'h0);
		@(posedge sys_clk);
		optOut <= 1'b1;
		repeat (3) @(posedge sys_clk);
		wr(`ADDR_CTRL, 32'h2);
		rchk("dirboth", `ADDR_CTRL, 32'h2, 32'h2);
		rchk("fitted", `ADDR_INFO, 32'h2, 32'h2);
		wr(`ADDR_CTRL, 32'h0);
		$display("direction test done");
		for (i = 0; i < 6; i = i + 1) begin
			wr(`ADDR_RATE, {14'h0, RATES[i*18 +: 18]});
			for (j = 0; j < 8; j = j + 1) begin
				wr(`ADDR_CTRL, {23'h0, j[2:0], 6'h0});
				ph = j[1:0] + {j[2], 1'b0};
				if (i == 0 || i == 5)
					ph[0] = 1'b0;
				rchk("phase", `ADDR_INFO, 32'h1C, {27'h0, i >= 3, ph, 2'h0});
			end
		end
		wr(`ADDR_RATE, {14'h0, `RATE_RESET});
		$display("phase test done");
		fmtOn <= 1'b0;
		wr(`ADDR_CTRL, 32'h5);
		rchk("noformat", `ADDR_CTRL, 32'h1, 32'h0);
		@(posedge sys_clk);
		fmtOn <= 1'b1;
		for (i = 0; i < 3; i = i + 1) begin
			wr(`ADDR_CTRL, 32'h1 | (i << 2));
			frame(i[1:0], 1'b0, 6'h2, 16'h1234 + i[15:0]);
			drain(6'h2, 16'h1234 + i[15:0]);
		end
		wr(`ADDR_CTRL, 32'h105);
		frame(`CFG_PARALLEL, 1'b1, 6'h3, 16'h5A00);
		drain(6'h3, 16'h5A00);
		$display("capture test done");
		wr(`ADDR_CTRL, 32'h5);
		rchk("stclean", `ADDR_STATUS, 32'h7, 32'h0);
		wr(`ADDR_MASK, 32'h0);
		frame(`CFG_PARALLEL, 1'b0, 6'h12, 16'hA000);
		chk("irqmasked", irq, 1'b0);
		wr(`ADDR_MASK, 32'h1);
		@(negedge sys_clk);
		chk("irqset", irq, 1'b1);
		rchk("errovf", `ADDR_ERRCODE, 32'h3FF, {22'h0, `ERR_OVERFLOW});
		rchk("stovf", `ADDR_STATUS, 32'h1, 32'h1);
		chk("irqclear", irq, 1'b0);
		drain(6'h10, 16'hA000);
		pull(v, sd);
		chk("udf", v, 1'b0);
		rchk("errudf", `ADDR_ERRCODE, 32'h3FF, {22'h0, `ERR_UNDERFLOW});
		rchk("studf", `ADDR_STATUS, 32'h3, 32'h2);
		$display("fifo test done");
		wr(`ADDR_LOGIC, 32'h2);
		@(negedge sys_clk);
		chk("logicheld", logicType, 2'h0);
		rchk("pending", `ADDR_LOGIC, 32'h7, 32'h6);
		wr(`ADDR_CONFIRM, 32'h0);
		@(negedge sys_clk);
		chk("logicset", logicType, 2'h2);
		rchk("applied", `ADDR_LOGIC, 32'h4, 32'h0);
		$display("logic test done");
		@(posedge sys_clk);
		useDev <= 1'b1;
		wr(`ADDR_CTRL, 32'h15);
		repeat (2) @(negedge sys_clk);
		chk("oedev", devClkOe, 1'b0);
		frame(`CFG_PARALLEL, 1'b0, 6'h2, 16'hC0DE);
		drain(6'h2, 16'hC0DE);
		@(posedge sys_clk);
		useDev <= 1'b0;
		wr(`ADDR_CTRL, 32'h25);
		repeat (2) @(negedge sys_clk);
		chk("oeint", devClkOe, 1'b1);
		countRises(cnt);
		chk("intclk", cnt >= 49 && cnt <= 51, 1'b1);
		rchk("reflock", `ADDR_INFO, 32'h20, 32'h20);
		wr(`ADDR_CTRL, 32'h5);
		countRises(cnt);
		chk("extidle", cnt, 32'h0);
		$display("clock test done");
		@(posedge sys_clk);
		fmtOn <= 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("fmtloss", moduleOn, 1'b0);
		rchk("stfmt", `ADDR_STATUS, 32'h4, 32'h4);
		$display("format test done");
		tally_and_finish;
	end
endmodule
